// ---- pkg/dual_conv_pkg.sv ----
/*
 package for the dual converter mode control and output routing block.
 holds widths, mode encodings, recovery counts and the carrier structs.
 assumes one 200 MHz system clock and a per-channel sample strobe.
*/
package dual_conv_pkg;

	// =========================================================
	// widths and codes
	localparam int SAMPLE_W = 10;               // sample word width
	localparam logic [9:0] CODE_MAX = 10'h3FF;  // full-scale top code
	localparam logic [9:0] CODE_MIN = 10'h000;  // full-scale bottom code
	localparam logic [9:0] MID_CODE = 10'h200;  // midscale offset
	localparam logic [9:0] RST_WORD = 10'h000;  // output word after reset

	// =========================================================
	// recovery times
	localparam int NAP_RECOVER_SAMPLES = 100;     // nap exit, sample clocks
	localparam int SLEEP_RECOVER_MS    = 2;       // sleep exit, ms
	localparam int CLK_MHZ             = 200;     // system clock rate
	localparam int SLEEP_RECOVER_CYC   =
		SLEEP_RECOVER_MS * CLK_MHZ * 1000;     // cycles, above 4096

	// =========================================================
	// power mode per channel
	typedef enum logic [1:0]
	{
		MODE_NORMAL = 2'b00,  // converting
		MODE_NAP    = 2'b01,  // reference kept on
		MODE_SLEEP  = 2'b10   // everything off
	} power_mode_t;

	// one converted sample with its range flag
	typedef struct packed
	{
		logic [9:0] word;  // sample word
		logic       flag;  // over or under range
	} sample_t;

	// per-channel state
	typedef struct packed
	{
		power_mode_t mode;    // current power mode
		logic        valid;   // data trustworthy
		logic [31:0] wait_n;  // remaining recovery count
		logic        by_smp;  // count in samples, not cycles
		sample_t     smp;     // last converted sample
	} chan_state_t;

endpackage : dual_conv_pkg

// ---- verilog/conv_channel.sv ----
`timescale 1ns/1ps
/*
 one converter channel: power mode decode, recovery count and sample
 capture with range flag. assumes samp_stb is one cycle per sample clock.
*/
module conv_channel #(
	parameter int SLEEP_CYC = dual_conv_pkg::SLEEP_RECOVER_CYC
)(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  pd_sel,     // power down select
	input  wire logic                  dis_n,      // output disable pin
	input  wire logic                  samp_stb,   // sample clock edge
	input  wire logic signed [10:0]    raw_in,     // signed input, +-512 fs
	output dual_conv_pkg::sample_t     smp_out,    // captured sample
	output dual_conv_pkg::power_mode_t mode_out,   // present mode
	output logic                       valid_out,  // data past recovery
	output logic                       drive_out   // outputs driven
);
	// refuse a recovery count the counter cannot serve
	if (SLEEP_CYC < 1)
	begin : g_bad_sleep
		$error("sleep recovery count must be positive");
	end

	dual_conv_pkg::chan_state_t st_reg;   // registered state
	dual_conv_pkg::chan_state_t st_next;  // next state
	logic signed [11:0]         off;      // offset binary, one spare bit

	// =========================================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		// widened so inputs past full scale cannot wrap round
		off     = {raw_in[10], raw_in} + {2'b00, dual_conv_pkg::MID_CODE};
		// own pins only decide the mode
		if (!pd_sel)
			st_next.mode = dual_conv_pkg::MODE_NORMAL;
		else if (dis_n)
			st_next.mode = dual_conv_pkg::MODE_SLEEP;
		else
			st_next.mode = dual_conv_pkg::MODE_NAP;
		// leaving a low-power mode starts the recovery
		if (st_next.mode == dual_conv_pkg::MODE_NORMAL &&
			st_reg.mode != dual_conv_pkg::MODE_NORMAL)
		begin
			st_next.valid  = 1'b0;
			st_next.by_smp = (st_reg.mode == dual_conv_pkg::MODE_NAP);
			st_next.wait_n = (st_reg.mode == dual_conv_pkg::MODE_NAP) ?
				32'(dual_conv_pkg::NAP_RECOVER_SAMPLES) :
				32'(SLEEP_CYC);
		end
		else if (st_next.mode != dual_conv_pkg::MODE_NORMAL)
		begin
			st_next.valid = 1'b0;
		end
		else if (st_reg.wait_n != 32'h0)
		begin
			// counts in samples after nap, cycles after sleep
			if (!st_reg.by_smp || samp_stb)
				st_next.wait_n = st_reg.wait_n - 32'h1;
			if (st_next.wait_n == 32'h0)
				st_next.valid = 1'b1;
		end
		// conversion only in normal mode
		if (st_reg.mode == dual_conv_pkg::MODE_NORMAL && samp_stb)
		begin
			if (off > 12'sh3FF)
			begin
				st_next.smp.word = dual_conv_pkg::CODE_MAX;
				st_next.smp.flag = 1'b1;
			end
			else if (off < 12'sh000)
			begin
				st_next.smp.word = dual_conv_pkg::CODE_MIN;
				st_next.smp.flag = 1'b1;
			end
			else
			begin
				st_next.smp.word = off[9:0];
				st_next.smp.flag = 1'b0;
			end
		end
	end

	// =========================================================
	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg <= '{mode: dual_conv_pkg::MODE_NORMAL, valid: 1'b1,
				wait_n: 32'h0, by_smp: 1'b0,
				smp: '{word: dual_conv_pkg::RST_WORD, flag: 1'b0}};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign smp_out   = st_reg.smp;
	assign mode_out  = st_reg.mode;
	assign valid_out = st_reg.valid;
	// float in nap, sleep, or when disabled
	assign drive_out = (st_reg.mode == dual_conv_pkg::MODE_NORMAL) &&
		!dis_n;

	// =========================================================
	// checks
	a_nap_decode: assert property (@(posedge clk) disable iff (rst)
		pd_sel && !dis_n |=> mode_out == dual_conv_pkg::MODE_NAP)
		else $error("nap not entered");
	a_sleep_decode: assert property (@(posedge clk) disable iff (rst)
		pd_sel && dis_n |=> mode_out == dual_conv_pkg::MODE_SLEEP)
		else $error("sleep not entered");
	a_normal_decode: assert property (@(posedge clk) disable iff (rst)
		!pd_sel |=> mode_out == dual_conv_pkg::MODE_NORMAL)
		else $error("normal not entered");
	a_lowpow_float: assert property (@(posedge clk) disable iff (rst)
		mode_out != dual_conv_pkg::MODE_NORMAL |-> !drive_out)
		else $error("outputs driven in low power");
	a_nap_invalid: assert property (@(posedge clk) disable iff (rst)
		mode_out == dual_conv_pkg::MODE_NAP && !pd_sel
		|=> !valid_out [*8])
		else $error("nap recovery too short");
	a_range_flag: assert property (@(posedge clk) disable iff (rst)
		mode_out == dual_conv_pkg::MODE_NORMAL && samp_stb &&
		(raw_in > 11'sh1FF || raw_in < -11'sh200)
		|=> smp_out.flag)
		else $error("range flag missing");
	c_nap_exit: cover property (@(posedge clk) disable iff (rst)
		mode_out == dual_conv_pkg::MODE_NAP ##1
		mode_out == dual_conv_pkg::MODE_NORMAL);
	c_sleep_exit: cover property (@(posedge clk) disable iff (rst)
		mode_out == dual_conv_pkg::MODE_SLEEP ##1
		mode_out == dual_conv_pkg::MODE_NORMAL);
	c_overrange: cover property (@(posedge clk) disable iff (rst)
		smp_out.flag);

endmodule : conv_channel

// ---- verilog/dual_conv_ctrl.sv ----
`timescale 1ns/1ps
/*
 top of the dual converter mode control: two independent channels and
 the output bus swap. assumes all pins synchronous to CLK_SYS, sample
 clocks edge detected here into one-cycle strobes, bus pins resolved outside.
*/
module dual_conv_ctrl #(
	parameter int SLEEP_CYC = dual_conv_pkg::SLEEP_RECOVER_CYC
)(
	input  wire logic               CLK_SYS,
	input  wire logic               SYS_RST,
	input  wire logic               CHAN_A_POWER_DOWN_SELECT,
	input  wire logic               CHAN_B_POWER_DOWN_SELECT,
	input  wire logic               CHAN_A_OUTPUT_DISABLE_N,
	input  wire logic               CHAN_B_OUTPUT_DISABLE_N,
	input  wire logic               BUS_SWAP_SELECT,
	input  wire logic               CHAN_A_SAMPLE_CLOCK,
	input  wire logic               CHAN_B_SAMPLE_CLOCK,
	input  wire logic signed [10:0] CHAN_A_ANALOG,
	input  wire logic signed [10:0] CHAN_B_ANALOG,
	output logic [9:0]              BUS_A_SAMPLE_WORD,
	output logic                    BUS_A_RANGE_FLAG,
	output logic                    BUS_A_OE,
	output logic [9:0]              BUS_B_SAMPLE_WORD,
	output logic                    BUS_B_RANGE_FLAG,
	output logic                    BUS_B_OE,
	output logic                    CHAN_A_DATA_VALID,
	output logic                    CHAN_B_DATA_VALID
);
	dual_conv_pkg::sample_t     smp_a, smp_b;    // channel samples
	logic                       drv_a, drv_b;    // channel drive enables
	logic                       clk_a_q, clk_b_q;// sample clock history

	// =========================================================
	// sample clock edge detect
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			clk_a_q <= 1'b0;
			clk_b_q <= 1'b0;
		end
		else
		begin
			clk_a_q <= CHAN_A_SAMPLE_CLOCK;
			clk_b_q <= CHAN_B_SAMPLE_CLOCK;
		end
	end

	// =========================================================
	// channels, each on its own pins only
	conv_channel #(.SLEEP_CYC(SLEEP_CYC)) u_chan_a (
		.clk(CLK_SYS), .rst(SYS_RST),
		.pd_sel(CHAN_A_POWER_DOWN_SELECT),
		.dis_n(CHAN_A_OUTPUT_DISABLE_N),
		.samp_stb(CHAN_A_SAMPLE_CLOCK && !clk_a_q),
		.raw_in(CHAN_A_ANALOG), .smp_out(smp_a), .mode_out(),
		.valid_out(CHAN_A_DATA_VALID), .drive_out(drv_a));
	conv_channel #(.SLEEP_CYC(SLEEP_CYC)) u_chan_b (
		.clk(CLK_SYS), .rst(SYS_RST),
		.pd_sel(CHAN_B_POWER_DOWN_SELECT),
		.dis_n(CHAN_B_OUTPUT_DISABLE_N),
		.samp_stb(CHAN_B_SAMPLE_CLOCK && !clk_b_q),
		.raw_in(CHAN_B_ANALOG), .smp_out(smp_b), .mode_out(),
		.valid_out(CHAN_B_DATA_VALID), .drive_out(drv_b));

	// =========================================================
	// output swap; enable travels with its channel
	always_comb
	begin
		if (BUS_SWAP_SELECT)
		begin
			{BUS_A_SAMPLE_WORD, BUS_A_RANGE_FLAG} = smp_a;
			{BUS_B_SAMPLE_WORD, BUS_B_RANGE_FLAG} = smp_b;
			BUS_A_OE = drv_a;
			BUS_B_OE = drv_b;
		end
		else
		begin
			{BUS_A_SAMPLE_WORD, BUS_A_RANGE_FLAG} = smp_b;
			{BUS_B_SAMPLE_WORD, BUS_B_RANGE_FLAG} = smp_a;
			BUS_A_OE = drv_b;
			BUS_B_OE = drv_a;
		end
	end

	a_swap_high: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		BUS_SWAP_SELECT |-> BUS_A_SAMPLE_WORD == smp_a.word &&
		BUS_B_RANGE_FLAG == smp_b.flag)
		else $error("swap high routing wrong");
	a_swap_low: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!BUS_SWAP_SELECT |-> BUS_B_SAMPLE_WORD == smp_a.word &&
		BUS_A_RANGE_FLAG == smp_b.flag)
		else $error("swap low routing wrong");
	// flags follow their words through the swap
	a_flag_high: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		BUS_SWAP_SELECT |-> BUS_A_RANGE_FLAG == smp_a.flag &&
		BUS_B_SAMPLE_WORD == smp_b.word)
		else $error("swap high flag routing wrong");
	a_flag_low: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!BUS_SWAP_SELECT |-> BUS_B_RANGE_FLAG == smp_a.flag &&
		BUS_A_SAMPLE_WORD == smp_b.word)
		else $error("swap low flag routing wrong");
	// a raised disable pin always floats the bus that carries its channel
	a_dis_float_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		CHAN_A_OUTPUT_DISABLE_N |->
		!(BUS_SWAP_SELECT ? BUS_A_OE : BUS_B_OE))
		else $error("channel a driven while disabled");
	a_dis_float_b: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		CHAN_B_OUTPUT_DISABLE_N |->
		!(BUS_SWAP_SELECT ? BUS_B_OE : BUS_A_OE))
		else $error("channel b driven while disabled");
	c_one_asleep: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
		drv_a && !drv_b);

endmodule : dual_conv_ctrl

// ---- bench/sample_sink.sv ----
/*
 downstream logic model: keeps the last trusted word of one bus.
 assumes bus pins are stable around CLK_SYS edges.
*/
`timescale 1ns/1ps
module sample_sink (
	input  wire logic       clk,
	input  wire logic       oe,
	input  wire logic       valid,
	input  wire logic [9:0] word,
	output logic [9:0]      kept_word
);
	// =========================================================
	// capture only driven, recovered data
	always @(posedge clk)
	begin
		if (oe && valid)
		begin
			kept_word <= word;
		end
	end
endmodule : sample_sink

// ---- bench/dual_conv_ctrl_tb.sv ----
/*
 testbench for the dual converter mode control and bus swap.
 assumes SLEEP_CYC shortened to 20 and one-cycle sample strobes.
*/
`timescale 1ns/1ps
module dual_conv_ctrl_tb;
	// =========================================================
	// pins and bookkeeping
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic pd_a = 1'h0, pd_b = 1'h0, dn_a = 1'h0, dn_b = 1'h0;
	logic swp = 1'h1, ck_a = 1'h0, ck_b = 1'h0;
	logic signed [10:0] an_a = 11'h000, an_b = 11'h000;
	logic [9:0] w_a, w_b, kept;
	logic f_a, f_b, oe_a, oe_b, v_a, v_b;
	int err_count = 0, tests_run = 0, cyc = 0;
	logic signed [10:0] tbl [5] = '{-512, 0, 511, 600, -600};

	dual_conv_ctrl #(.SLEEP_CYC(20)) dual_conv_ctrl_inst (
		.CLK_SYS(clk), .SYS_RST(rst),
		.CHAN_A_POWER_DOWN_SELECT(pd_a), .CHAN_B_POWER_DOWN_SELECT(pd_b),
		.CHAN_A_OUTPUT_DISABLE_N(dn_a), .CHAN_B_OUTPUT_DISABLE_N(dn_b),
		.BUS_SWAP_SELECT(swp),
		.CHAN_A_SAMPLE_CLOCK(ck_a), .CHAN_B_SAMPLE_CLOCK(ck_b),
		.CHAN_A_ANALOG(an_a), .CHAN_B_ANALOG(an_b),
		.BUS_A_SAMPLE_WORD(w_a), .BUS_A_RANGE_FLAG(f_a), .BUS_A_OE(oe_a),
		.BUS_B_SAMPLE_WORD(w_b), .BUS_B_RANGE_FLAG(f_b), .BUS_B_OE(oe_b),
		.CHAN_A_DATA_VALID(v_a), .CHAN_B_DATA_VALID(v_b));

	sample_sink sample_sink_inst (.clk(clk), .oe(oe_a), .valid(v_a),
		.word(w_a), .kept_word(kept));

	// clock, 5 ns period
	initial forever #2.5 clk = ~clk;

	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			tally_and_finish();
		end
	end

	// =========================================================
	// helpers
	// expected offset-binary word and range flag
	function automatic logic [10:0] cv(input logic signed [10:0] r);
		if (r > 511) return {10'h3FF, 1'h1};
		if (r < -512) return {10'h000, 1'h1};
		return {r[9:0] ^ 10'h200, 1'h0};
	endfunction : cv

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// one sample edge on the chosen channels
	// four cycles a sample keeps the rate near 50 Msps
	task automatic smp(input logic a, b, input logic signed [10:0] x, y);
		an_a = x;
		an_b = y;
		ck_a = a;
		ck_b = b;
		tick(1);
		ck_a = 1'h0;
		ck_b = 1'h0;
		tick(3);
	endtask : smp

	task automatic chk_word(input logic [10:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t word %h want %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t bit %b want %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// =========================================================
	// test sequence
	initial
	begin
		tick(6);
		rst = 1'h0;
		// codes, range flag and both swap settings
		// both channels strobed together, one clock for both
		foreach (tbl[i])
		begin
			smp(1'h1, 1'h1, tbl[i], -tbl[i]);
			chk_word({w_a, f_a}, cv(tbl[i]));
			chk_word({w_b, f_b}, cv(-tbl[i]));
			swp = 1'h0;
			tick(1);
			chk_word({w_b, f_b}, cv(tbl[i]));
			chk_word({w_a, f_a}, cv(-tbl[i]));
			swp = 1'h1;
		end
		$display("test conv_swap done");
		// nap on a while b converts
		pd_a = 1'h1;
		tick(2);
		chk_bit(oe_a, 1'h0);
		chk_bit(v_a, 1'h0);
		chk_bit(oe_b, 1'h1);
		smp(1'h1, 1'h1, 11'sd100, 11'sd5);
		chk_word({w_b, f_b}, cv(11'sd5));
		pd_a = 1'h0;
		tick(2);
		chk_bit(oe_a, 1'h1);
		repeat (99) smp(1'h1, 1'h0, 11'sd7, 11'sd0);
		chk_bit(v_a, 1'h0);
		smp(1'h1, 1'h0, 11'sd7, 11'sd0);
		chk_bit(v_a, 1'h1);
		chk_word({kept, 1'h0}, cv(11'sd7));
		$display("test nap done");
		// sleep on b, a untouched
		pd_b = 1'h1;
		dn_b = 1'h1;
		tick(2);
		chk_bit(oe_b, 1'h0);
		chk_bit(v_a, 1'h1);
		pd_b = 1'h0;
		dn_b = 1'h0;
		tick(10);
		chk_bit(v_b, 1'h0);
		tick(20);
		chk_bit(v_b, 1'h1);
		$display("test sleep done");
		// output disable alone
		dn_a = 1'h1;
		tick(2);
		chk_bit(oe_a, 1'h0);
		chk_bit(oe_b, 1'h1);
		dn_a = 1'h0;
		tick(2);
		chk_bit(oe_a, 1'h1);
		// unused bus b switched off while a carries data
		dn_b = 1'h1;
		tick(2);
		chk_bit(oe_b, 1'h0);
		chk_bit(oe_a, 1'h1);
		dn_b = 1'h0;
		tick(2);
		$display("test disable done");
		tally_and_finish();
	end
endmodule : dual_conv_ctrl_tb
